// file: rtl/dpram_host.sv
// Port controller: AXI4-Lite register slave driving one RAM port
`timescale 1ns/1ps
`default_nettype none
module dpram_host
    import dpram_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [AXI_AW-1:0] awaddr, // Write byte address
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    output logic [1:0] bresp, // Write response
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    input wire logic [AXI_AW-1:0] araddr, // Read byte address
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    dpram_port_if.ctrl pins // RAM port pins
);
    host_state_e state_ff, nxt_state;
    logic [1:0] lat_ff, nxt_lat;
    logic aw_take, wr_fire, ar_take, ar_fire;
    logic hit_addr, hit_wdata, hit_cmd, hit_cfg, wr_known, rd_known;
    logic start, iss, capture, done_set;
    logic [31:0] wmerge_a, wmerge_d, rd_mux;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic [4:0] cmd_ff;
    logic mode_ff, done_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_bus_ff;
    logic sel_n_ff, rw_n_ff, ads_n_ff, counter_advance_enable_n_ff, clr_n_ff, oe_n_ff;
    logic ub_n_ff, lb_n_ff;
    logic [ADDR_W-1:0] apin_ff;
    logic [DATA_W-1:0] dpin_ff;
    logic [LANES-1:0] doe_ff;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    assign aw_take = awvalid && wvalid && !awready_ff && !bvalid_ff;
    assign wr_fire = awvalid && awready_ff && wvalid && wready_ff;
    assign ar_take = arvalid && !arready_ff && !rvalid_ff;
    assign ar_fire = arvalid && arready_ff;
    assign hit_addr = wr_fire && awaddr == REG_ADDR;
    assign hit_wdata = wr_fire && awaddr == REG_WDATA;
    assign hit_cmd = wr_fire && awaddr == REG_CMD;
    assign hit_cfg = wr_fire && awaddr == REG_CFG;
    assign wr_known = hit_addr || hit_wdata || hit_cmd || hit_cfg;
    assign rd_known = araddr == REG_ADDR || araddr == REG_WDATA ||
        araddr == REG_CMD || araddr == REG_CFG || araddr == REG_STATUS;
    assign wmerge_a = merge(32'(addr_ff), wdata, wstrb);
    assign wmerge_d = merge(32'(wdata_ff), wdata, wstrb);
    assign start = hit_cmd && state_ff == st_idle;
    assign iss = nxt_state == st_issue;
    assign capture = state_ff == st_wait && lat_ff == LAT_LAST;
    assign done_set = capture || (state_ff == st_issue && cmd_ff[CMD_WRITE]);
    assign rd_mux = araddr == REG_ADDR ? 32'(addr_ff) :
        araddr == REG_WDATA ? 32'(wdata_ff) :
        araddr == REG_CMD ? 32'(cmd_ff) :
        araddr == REG_CFG ? 32'(mode_ff) :
        araddr == REG_STATUS ? {rdata_ff, 14'h0000, done_ff,
        state_ff != st_idle} : 32'h00000000;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_lat = lat_ff;
        unique case (state_ff)
            st_idle: nxt_state = start ? st_issue : st_idle;
            st_issue:
            begin
                nxt_state = cmd_ff[CMD_WRITE] ? st_idle : st_wait;
                nxt_lat = mode_ff ? PIPE_LAT_CYC : FLOW_LAT_CYC;
            end
            st_wait:
            begin
                nxt_state = capture ? st_idle : st_wait;
                nxt_lat = lat_ff - 2'h1;
            end
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            awready_ff <= aw_take;
            wready_ff <= aw_take;
            bvalid_ff <= wr_fire || (bvalid_ff && !bready);
            bresp_ff <= wr_fire ? (wr_known ? RESP_OKAY : RESP_SLVERR) :
                bresp_ff;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_bus_ff <= 32'h00000000;
        end
        else
        begin
            arready_ff <= ar_take;
            rvalid_ff <= ar_fire || (rvalid_ff && !rready);
            if (ar_fire)
            begin
                rresp_ff <= rd_known ? RESP_OKAY : RESP_SLVERR;
                rdata_bus_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_ff <= ADDR_ZERO;
            wdata_ff <= '0;
            cmd_ff <= 5'h00;
            mode_ff <= 1'b0;
        end
        else
        begin
            addr_ff <= hit_addr ? wmerge_a[ADDR_W-1:0] : addr_ff;
            wdata_ff <= hit_wdata ? wmerge_d[DATA_W-1:0] : wdata_ff;
            cmd_ff <= start ? wdata[4:0] : cmd_ff;
            // Mode only changes while the port is quiet
            if (hit_cfg && state_ff == st_idle && wstrb[0])
            begin
                mode_ff <= wdata[CFG_MODE];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= st_idle;
            lat_ff <= 2'h0;
            rdata_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            lat_ff <= nxt_lat;
            rdata_ff <= capture ? pins.dq_level : rdata_ff;
            // A completion in the clearing cycle is kept
            done_ff <= done_set || (done_ff && !hit_cmd);
        end
    end

    // Port stays selected so a pipelined read is never the first
    // selected cycle, and no idle cycle sits between read and write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_n_ff <= 1'b1;
            rw_n_ff <= 1'b1;
            ads_n_ff <= 1'b1;
            counter_advance_enable_n_ff <= 1'b1;
            clr_n_ff <= 1'b1;
            ub_n_ff <= 1'b0;
            lb_n_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            apin_ff <= ADDR_ZERO;
            dpin_ff <= '0;
            doe_ff <= '0;
        end
        else
        begin
            sel_n_ff <= 1'b0;
            rw_n_ff <= !(iss && wdata[CMD_WRITE]);
            ads_n_ff <= !(iss && !wdata[CMD_COUNTER]);
            counter_advance_enable_n_ff <= !(iss && wdata[CMD_COUNTER]);
            clr_n_ff <= !(iss && wdata[CMD_CLEAR]);
            ub_n_ff <= iss && wdata[CMD_UPPER_OFF];
            lb_n_ff <= iss && wdata[CMD_LOWER_OFF];
            // Drive enable low only in the cycle the read word is sampled
            oe_n_ff <= !(nxt_state == st_wait && nxt_lat == LAT_LAST);
            apin_ff <= iss ? addr_ff : apin_ff;
            dpin_ff <= iss ? wdata_ff : dpin_ff;
            doe_ff <= (iss && wdata[CMD_WRITE]) ?
                ~{wdata[CMD_UPPER_OFF], wdata[CMD_LOWER_OFF]} : 2'h0;
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_bus_ff;
    assign rresp = rresp_ff;
    assign pins.addr = apin_ff;
    assign pins.select_active_low = sel_n_ff;
    assign pins.select_active_high = !sel_n_ff;
    assign pins.read_write_n = rw_n_ff;
    assign pins.address_load_strobe_n = ads_n_ff;
    assign pins.counter_advance_enable_n = counter_advance_enable_n_ff;
    assign pins.counter_clear_n = clr_n_ff;
    assign pins.upper_byte_select_n = ub_n_ff;
    assign pins.lower_byte_select_n = lb_n_ff;
    assign pins.output_drive_enable_n = oe_n_ff;
    assign pins.output_stage_mode = mode_ff;
    assign pins.host_d = dpin_ff;
    assign pins.host_d_oe = doe_ff;
endmodule
`default_nettype wire

// file: rtl/dpram_pkg.sv
// Shared constants and types for the dual-port RAM port and its controller
package dpram_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int DEPTH = 32768;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
    localparam int CLK_PERIOD_NS = 10;
    // Read latency in cycles of aclk, counted from the capturing edge
    localparam logic [1:0] FLOW_LAT_CYC = 2'h1;
    localparam logic [1:0] PIPE_LAT_CYC = 2'h2;
    localparam logic [1:0] LAT_LAST = 2'h1;
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_ADDR = 8'h00;
    localparam logic [AXI_AW-1:0] REG_WDATA = 8'h04;
    localparam logic [AXI_AW-1:0] REG_CMD = 8'h08;
    localparam logic [AXI_AW-1:0] REG_CFG = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h10;
    localparam int CMD_WRITE = 0;
    localparam int CMD_UPPER_OFF = 1;
    localparam int CMD_LOWER_OFF = 2;
    localparam int CMD_COUNTER = 3;
    localparam int CMD_CLEAR = 4;
    localparam int CFG_MODE = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_RDATA = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0]
    {
        st_idle = 2'b00,
        st_issue = 2'b01,
        st_wait = 2'b10
    } host_state_e;
endpackage

// file: rtl/dpram_port_if.sv
// Pin bundle of one RAM port, shared by the RAM and its controller
`timescale 1ns/1ps
`default_nettype none
interface dpram_port_if;
    import dpram_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic select_active_low;
    logic select_active_high;
    logic read_write_n;
    logic address_load_strobe_n;
    logic counter_advance_enable_n;
    logic counter_clear_n;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
    logic output_drive_enable_n;
    logic output_stage_mode;
    logic [DATA_W-1:0] host_d;
    logic [LANES-1:0] host_d_oe;
    logic [DATA_W-1:0] ram_q;
    logic [LANES-1:0] ram_q_oe;
    logic [DATA_W-1:0] dq_level;

    // Wire level of the shared data pins, worked out from both enables
    for (genvar g = 0; g < LANES; g++)
    begin : lane
        assign dq_level[g*LANE_W +: LANE_W] =
            ({LANE_W{host_d_oe[g]}} & host_d[g*LANE_W +: LANE_W]) |
            ({LANE_W{ram_q_oe[g]}} & ram_q[g*LANE_W +: LANE_W]);
    end

    modport ctrl (
        output addr, select_active_low, select_active_high, read_write_n,
        output address_load_strobe_n, counter_advance_enable_n,
        output counter_clear_n, upper_byte_select_n, lower_byte_select_n,
        output output_drive_enable_n, output_stage_mode, host_d, host_d_oe,
        input dq_level
    );
    modport ram (
        input addr, select_active_low, select_active_high, read_write_n,
        input address_load_strobe_n, counter_advance_enable_n,
        input counter_clear_n, upper_byte_select_n, lower_byte_select_n,
        input output_drive_enable_n, output_stage_mode, dq_level,
        output ram_q, ram_q_oe
    );
endinterface
`default_nettype wire

// file: rtl/dpram_device.sv
// Synchronous dual-port RAM: per-port pin logic and the shared array
`timescale 1ns/1ps
`default_nettype none

module dpram_port
    import dpram_pkg::*;
(
    input wire logic aclk, // Port clock
    input wire logic aresetn, // Synchronous reset, low
    dpram_port_if.ram pins, // Port pins
    input wire logic [DATA_W-1:0] raw_q, // Array word at acc_addr
    output logic [ADDR_W-1:0] acc_addr, // Address of this cycle
    output logic [DATA_W-1:0] wr_data, // Write data from pins
    output logic [LANES-1:0] wr_lanes // Lanes written this edge
);
    logic selected;
    logic is_read;
    logic is_write;
    logic [LANES-1:0] lane_on;
    logic [ADDR_W-1:0] adv_addr;
    logic [ADDR_W-1:0] load_addr;
    logic [ADDR_W-1:0] cnt_ff;
    logic [ADDR_W-1:0] nxt_cnt;
    logic [DATA_W-1:0] flow_q_ff;
    logic [DATA_W-1:0] pipe_q_ff;
    logic [LANES-1:0] flow_drv_ff;
    logic [LANES-1:0] pipe_drv_ff;
    logic sel_prev_ff;
    logic sel_old_ff;
    logic [LANES-1:0] drv;

    assign selected = !pins.select_active_low && pins.select_active_high;
    assign is_read = selected && pins.read_write_n;
    assign is_write = selected && !pins.read_write_n;
    assign lane_on = ~{pins.upper_byte_select_n, pins.lower_byte_select_n};

    // Counter output, advanced or held
    assign adv_addr = !pins.counter_advance_enable_n ?
        cnt_ff + ADDR_STEP : cnt_ff;
    // External address when the strobe is low
    assign load_addr = !pins.address_load_strobe_n ?
        pins.addr : adv_addr;
    // Clear wins and the same cycle already uses word zero
    assign nxt_cnt = !pins.counter_clear_n ?
        ADDR_ZERO : load_addr;
    assign acc_addr = nxt_cnt;

    assign wr_data = pins.dq_level;
    assign wr_lanes = lane_on & {LANES{is_write}};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_ff <= ADDR_ZERO;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Read word registered at the sampling edge; a read in the same
    // cycle as a write from the other port still sees the old word
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flow_q_ff <= '0;
            pipe_q_ff <= '0;
        end
        else
        begin
            if (is_read)
            begin
                flow_q_ff <= raw_q;
            end
            pipe_q_ff <= flow_q_ff;
        end
    end

    // Drive state taken from controls of the previous cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flow_drv_ff <= '0;
            sel_prev_ff <= 1'b0;
            sel_old_ff <= 1'b0;
            pipe_drv_ff <= '0;
        end
        else
        begin
            flow_drv_ff <= lane_on & {LANES{is_read}};
            sel_prev_ff <= selected;
            sel_old_ff <= sel_prev_ff;
            // Pipelined: the read cycle and the one before must be selected
            pipe_drv_ff <= flow_drv_ff & {LANES{sel_old_ff}};
        end
    end

    // Mode pin is treated as static, so it may steer the mux directly
    assign drv = pins.output_stage_mode ? pipe_drv_ff : flow_drv_ff;
    assign pins.ram_q = pins.output_stage_mode ? pipe_q_ff : flow_q_ff;
    // Asynchronous gate: with the mode mux, the only path not from a flip-flop
    assign pins.ram_q_oe = drv & {LANES{!pins.output_drive_enable_n}};
endmodule

module dpram_device
    import dpram_pkg::*;
#(
    parameter int WORDS = DEPTH
)
(
    input wire logic aclk, // Clock of both ports
    input wire logic aresetn, // Synchronous reset, low
    dpram_port_if.ram port_a, // First port pins
    dpram_port_if.ram port_b // Second port pins
);
    logic [DATA_W-1:0] mem [WORDS];
    logic [ADDR_W-1:0] acc_addr [2];
    logic [DATA_W-1:0] wr_data [2];
    logic [LANES-1:0] wr_lanes [2];
    logic [DATA_W-1:0] raw_q [2];

    assign raw_q[0] = mem[acc_addr[0]];
    assign raw_q[1] = mem[acc_addr[1]];

    // Same port logic on either side
    dpram_port u_port_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(port_a),
        .raw_q(raw_q[0]),
        .acc_addr(acc_addr[0]),
        .wr_data(wr_data[0]),
        .wr_lanes(wr_lanes[0])
    );

    dpram_port u_port_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(port_b),
        .raw_q(raw_q[1]),
        .acc_addr(acc_addr[1]),
        .wr_data(wr_data[1]),
        .wr_lanes(wr_lanes[1])
    );

    // Array is not reset. On a same-word same-lane collision the
    // second port wins; the cells give no better guarantee.
    always_ff @(posedge aclk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (wr_lanes[p][l])
                begin
                    mem[acc_addr[p]][l*LANE_W +: LANE_W] <=
                        wr_data[p][l*LANE_W +: LANE_W];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/dpram_sva.sv
// Assertions on the pins of the first RAM port
`timescale 1ns/1ps
`default_nettype none
module dpram_sva
    import dpram_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, low
    input wire logic select_active_low, // Select, low
    input wire logic select_active_high, // Select, high
    input wire logic read_write_n, // 1 read
    input wire logic address_load_strobe_n, // Load, low
    input wire logic counter_advance_enable_n, // Advance, low
    input wire logic counter_clear_n, // Clear, low
    input wire logic upper_byte_select_n, // Upper lane, low
    input wire logic lower_byte_select_n, // Lower lane, low
    input wire logic output_drive_enable_n, // Drive gate, low
    input wire logic output_stage_mode, // 1 pipelined
    input wire logic [LANES-1:0] host_d_oe, // Host drive
    input wire logic [LANES-1:0] ram_q_oe // RAM drive
);
    wire logic sel = !select_active_low && select_active_high;
    wire logic rd = sel && read_write_n;
    wire logic pipe = output_stage_mode;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Pipelined deselect is double buffered, so only flow mode is timed
    deselect_float_a: assert property (!pipe && !sel |=>
        ram_q_oe == 2'h0) else $error("output driven after deselect");
    flow_drive_a: assert property (!pipe && ram_q_oe != 2'h0 |->
        $past(rd) && !output_drive_enable_n)
        else $error("flow output not caused by a read");
    pipe_reenable_a: assert property (pipe && ram_q_oe != 2'h0 |->
        $past(read_write_n, 2) && $past(sel, 2) && $past(sel, 3))
        else $error("pipelined output without two selected cycles");
    upper_lane_a: assert property (ram_q_oe[1] |->
        !(pipe ? $past(upper_byte_select_n, 2) : $past(upper_byte_select_n)))
        else $error("upper lane driven while off");
    lower_lane_a: assert property (ram_q_oe[0] |->
        !(pipe ? $past(lower_byte_select_n, 2) : $past(lower_byte_select_n)))
        else $error("lower lane driven while off");
    async_gate_a: assert property (output_drive_enable_n |->
        ram_q_oe == 2'h0) else $error("output driven while gated off");
    write_lanes_a: assert property (host_d_oe != 2'h0 |->
        !read_write_n && (host_d_oe & {upper_byte_select_n,
        lower_byte_select_n}) == 2'h0) else $error("host drove an off lane");
    no_contention_a: assert property ((host_d_oe & ram_q_oe) == 2'h0)
        else $error("both ends drive one lane");
    one_cycle_cmd_a: assert property (!address_load_strobe_n |=>
        address_load_strobe_n)
        else $error("load strobe longer than one cycle");
    mode_static_a: assert property ($changed(output_stage_mode) |->
        $past(address_load_strobe_n) && $past(counter_advance_enable_n)
        && $past(counter_clear_n))
        else $error("output stage mode changed during an access");
endmodule
`default_nettype wire

// file: tb/sync_dual_port_ram_port_timing_tb_top.sv
// Bench: two AXI4-Lite port controllers sharing the dual-port RAM
`timescale 1ns/1ps
`default_nettype none
module sync_dual_port_ram_port_timing_tb_top;
    import dpram_pkg::*;
    localparam logic [4:0] WR = 5'h01;
    localparam logic [4:0] UP_OFF = 5'h02;
    localparam logic [4:0] LO_OFF = 5'h04;
    localparam logic [4:0] CNT = 5'h08;
    localparam logic [4:0] CLR = 5'h10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [1:0] awvalid = 2'h0;
    logic [1:0] wvalid = 2'h0;
    logic [1:0] bready = 2'h0;
    logic [1:0] arvalid = 2'h0;
    logic [1:0] rready = 2'h0;
    logic [AXI_AW-1:0] awaddr [2];
    logic [AXI_AW-1:0] araddr [2];
    logic [31:0] wdata [2];
    wire [1:0] awready;
    wire [1:0] wready;
    wire [1:0] bvalid;
    wire [1:0] arready;
    wire [1:0] rvalid;
    wire [1:0] bresp [2];
    wire [1:0] rresp [2];
    wire [31:0] rdata [2];
    int n_errors = 0;
    int n_compared = 0;

    always #5 aclk = ~aclk;

    dpram_port_if pins [2] ();
    dpram_device dpram_device_i (.aclk(aclk), .aresetn(aresetn),
        .port_a(pins[0]), .port_b(pins[1]));
    for (genvar g = 0; g < 2; g++)
    begin : host
        dpram_host dpram_host_i (.aclk(aclk), .aresetn(aresetn),
            .awvalid(awvalid[g]), .awready(awready[g]), .awaddr(awaddr[g]),
            .wvalid(wvalid[g]), .wready(wready[g]), .wdata(wdata[g]),
            .wstrb(4'hF), .bvalid(bvalid[g]), .bready(bready[g]),
            .bresp(bresp[g]), .arvalid(arvalid[g]), .arready(arready[g]),
            .araddr(araddr[g]), .rvalid(rvalid[g]), .rready(rready[g]),
            .rdata(rdata[g]), .rresp(rresp[g]), .pins(pins[g]));
    end
    dpram_sva dpram_sva_i (.aclk(aclk), .aresetn(aresetn),
        .select_active_low(pins[0].select_active_low),
        .select_active_high(pins[0].select_active_high),
        .read_write_n(pins[0].read_write_n),
        .address_load_strobe_n(pins[0].address_load_strobe_n),
        .counter_advance_enable_n(pins[0].counter_advance_enable_n),
        .counter_clear_n(pins[0].counter_clear_n),
        .upper_byte_select_n(pins[0].upper_byte_select_n),
        .lower_byte_select_n(pins[0].lower_byte_select_n),
        .output_drive_enable_n(pins[0].output_drive_enable_n),
        .output_stage_mode(pins[0].output_stage_mode),
        .host_d_oe(pins[0].host_d_oe), .ram_q_oe(pins[0].ram_q_oe));

    task automatic final_report();
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_resp(input string name, input logic [1:0] exp,
        input logic [1:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic hang(input string name);
        n_errors++;
        $display("wrong value %s expected %h seen %h", name, 1'b1, 1'b0);
        final_report();
    endtask

    // Address and data go up together; each is dropped once taken
    task automatic axi_wr(input int p, input logic [7:0] a,
        input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awvalid[p] <= 1'b1;
        awaddr[p] <= a;
        wvalid[p] <= 1'b1;
        wdata[p] <= d;
        bready[p] <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awready[p] === 1'b1)
                awvalid[p] <= 1'b0;
            if (wready[p] === 1'b1)
                wvalid[p] <= 1'b0;
            if (bvalid[p] === 1'b1)
                break;
        end
        if (i == 50)
            hang("write response");
        r = bresp[p];
        bready[p] <= 1'b0;
    endtask

    task automatic axi_rd(input int p, input logic [7:0] a,
        output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        arvalid[p] <= 1'b1;
        araddr[p] <= a;
        rready[p] <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arready[p] === 1'b1)
                arvalid[p] <= 1'b0;
            if (rvalid[p] === 1'b1)
                break;
        end
        if (i == 50)
            hang("read response");
        d = rdata[p];
        r = rresp[p];
        rready[p] <= 1'b0;
    endtask

    // One RAM access through the registers; waits for done
    task automatic ram_op(input int p, input logic [14:0] a,
        input logic [15:0] d, input logic [4:0] c, output logic [15:0] q);
        logic [31:0] s;
        logic [1:0] r;
        int i;
        axi_wr(p, REG_ADDR, {17'h00000, a}, r);
        axi_wr(p, REG_WDATA, {16'h0000, d}, r);
        axi_wr(p, REG_CMD, {27'h0000000, c}, r);
        for (i = 0; i < 20; i++)
        begin
            axi_rd(p, REG_STATUS, s, r);
            if (s[ST_DONE] === 1'b1 && s[ST_BUSY] === 1'b0)
                break;
        end
        if (i == 20)
            hang("access done");
        q = s[ST_RDATA +: 16];
    endtask

    initial
    begin
        logic [31:0] d;
        logic [15:0] q;
        logic [15:0] v;
        logic [14:0] a;
        logic [1:0] r;
        int o;
        foreach (awaddr[i])
        begin
            awaddr[i] = 8'h00;
            araddr[i] = 8'h00;
            wdata[i] = 32'h00000000;
        end
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(0, 8'h14, d, r);
        check_resp("unmapped read", RESP_SLVERR, r);
        check_word("unmapped rdata", 32'h00000000, d);
        axi_rd(1, 8'h02, d, r);
        check_resp("misaligned read", RESP_SLVERR, r);
        axi_wr(0, REG_STATUS, 32'h00000000, r);
        check_resp("status write", RESP_SLVERR, r);
        for (int m = 0; m < 2; m++)
        begin
            axi_wr(0, REG_CFG, 32'(m), r);
            check_resp("mode write", RESP_OKAY, r);
            axi_wr(1, REG_CFG, 32'(m), r);
            for (int p = 0; p < 2; p++)
            begin
                o = 1 - p;
                a = 15'h0028 + 15'(2 * m + p);
                v = 16'hA5C3 + 16'(2 * m + p);
                ram_op(p, a, v, WR, q);
                ram_op(o, a, 16'h0000, 5'h00, q);
                check_word("other port", 32'(v), 32'(q));
                ram_op(p, a, 16'h1234, WR | LO_OFF, q);
                ram_op(o, a, 16'h0000, UP_OFF, q);
                check_word("upper off", 32'(v[7:0]), 32'(q));
                ram_op(p, a, 16'h0000, LO_OFF, q);
                check_word("lower off", 32'h00001200, 32'(q));
            end
            v = 16'h1000 + 16'(256 * m);
            ram_op(m, 15'h0000, v, WR, q);
            ram_op(m, 15'h0007, v + 16'h0001, WR | CNT, q);
            ram_op(m, 15'h0007, v + 16'h0002, WR | CNT, q);
            ram_op(1 - m, 15'h0001, 16'h0000, 5'h00, q);
            check_word("counter write", 32'(v + 16'h0001), 32'(q));
            ram_op(m, 15'h0002, 16'h0000, CLR, q);
            check_word("clear read", 32'(v), 32'(q));
            ram_op(m, 15'h0005, 16'h0000, CNT, q);
            check_word("advance one", 32'(v + 16'h0001), 32'(q));
            ram_op(m, 15'h0005, 16'h0000, CNT, q);
            check_word("advance two", 32'(v + 16'h0002), 32'(q));
        end
        axi_rd(1, REG_CMD, d, r);
        check_word("command readback", {27'h0000000, CNT}, d);
        final_report();
    end
endmodule
`default_nettype wire
